// >>> src/tmi_flags.sv
`timescale 1ns/1ps

module tmi_flags (
	// Clock and reset
	input  wire logic                         clock,
	input  wire logic                         rstn,
	// Configuration and CPU state
	input  wire logic                         legacy_mode,
	input  wire logic                         global_irq_en,
	// I/O register port
	input  wire logic [tmi_pkg::ADDR_W-1:0]   io_addr,
	input  wire logic                         io_wr,
	input  wire logic                         io_rd,
	input  wire logic [tmi_pkg::DATA_W-1:0]   io_wdata,
	output logic      [tmi_pkg::DATA_W-1:0]   io_rdata,
	// Timer 1 state
	input  wire logic                         t1_tick,
	input  wire logic [15:0]                  t1_counter,
	input  wire logic [15:0]                  t1_compare_a,
	input  wire logic [15:0]                  t1_compare_b,
	input  wire logic [15:0]                  t1_compare_c,
	input  wire logic [15:0]                  t1_capture_value,
	input  wire logic [3:0]                   t1_waveform_mode_select,
	input  wire logic                         t1_mode_ovf_evt,
	input  wire logic                         t1_cap_rising,
	input  wire logic                         t1_capture_pin,
	// Timer 3 state
	input  wire logic                         t3_tick,
	input  wire logic [15:0]                  t3_counter,
	input  wire logic [15:0]                  t3_compare_a,
	input  wire logic [15:0]                  t3_compare_b,
	input  wire logic [15:0]                  t3_compare_c,
	input  wire logic [15:0]                  t3_capture_value,
	input  wire logic [3:0]                   t3_waveform_mode_select,
	input  wire logic                         t3_mode_ovf_evt,
	input  wire logic                         t3_cap_rising,
	input  wire logic                         t3_capture_pin,
	// Interrupt vectors
	input  wire logic [tmi_pkg::NUM_SRC-1:0]  vec_taken,
	output logic      [tmi_pkg::NUM_SRC-1:0]  irq_req
);

	// Capture register used as TOP
	function automatic logic cap_is_top(input logic [3:0] m);
		cap_is_top = (m == tmi_pkg::WGM_PFC_ICR) || (m == tmi_pkg::WGM_PC_ICR)
			|| (m == tmi_pkg::WGM_CTC_ICR) || (m == tmi_pkg::WGM_FAST_ICR);
	endfunction

	// Overflow taken at MAX rather than from the waveform logic
	function automatic logic ovf_at_max(input logic [3:0] m);
		ovf_at_max = (m == tmi_pkg::WGM_NORMAL) || (m == tmi_pkg::WGM_CTC_OCR)
			|| (m == tmi_pkg::WGM_CTC_ICR);
	endfunction

	// Address match shared by the write decode and the read mux
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
		reg_hit = (a == off);
	endfunction

	// Source vector to register image; bits with no source read zero
	function automatic logic [7:0] pack_shared(input logic [9:0] v);
		logic [7:0] r;
		r = 8'h00;
		r[tmi_pkg::SH_T1_CAP] = v[tmi_pkg::K_CAP];
		r[tmi_pkg::SH_T1_A]   = v[tmi_pkg::K_A];
		r[tmi_pkg::SH_T1_B]   = v[tmi_pkg::K_B];
		r[tmi_pkg::SH_T1_OVF] = v[tmi_pkg::K_OVF];
		pack_shared = r;
	endfunction

	function automatic logic [7:0] pack_ext(input logic [9:0] v);
		logic [7:0] r;
		r = 8'h00;
		r[tmi_pkg::EX_T3_CAP] = v[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_CAP];
		r[tmi_pkg::EX_T3_A]   = v[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_A];
		r[tmi_pkg::EX_T3_B]   = v[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_B];
		r[tmi_pkg::EX_T3_OVF] = v[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_OVF];
		r[tmi_pkg::EX_T3_C]   = v[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_C];
		r[tmi_pkg::EX_T1_C]   = v[tmi_pkg::K_C];
		pack_ext = r;
	endfunction

	// Register image to source vector, for clears and enables
	function automatic logic [9:0] unpack_shared(input logic [7:0] d);
		logic [9:0] r;
		r = 10'h000;
		r[tmi_pkg::K_CAP] = d[tmi_pkg::SH_T1_CAP];
		r[tmi_pkg::K_A]   = d[tmi_pkg::SH_T1_A];
		r[tmi_pkg::K_B]   = d[tmi_pkg::SH_T1_B];
		r[tmi_pkg::K_OVF] = d[tmi_pkg::SH_T1_OVF];
		unpack_shared = r;
	endfunction

	function automatic logic [9:0] unpack_ext(input logic [7:0] d);
		logic [9:0] r;
		r = 10'h000;
		r[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_CAP] = d[tmi_pkg::EX_T3_CAP];
		r[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_A]   = d[tmi_pkg::EX_T3_A];
		r[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_B]   = d[tmi_pkg::EX_T3_B];
		r[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_OVF] = d[tmi_pkg::EX_T3_OVF];
		r[tmi_pkg::SRC_PER_TMR + tmi_pkg::K_C]   = d[tmi_pkg::EX_T3_C];
		r[tmi_pkg::K_C]                          = d[tmi_pkg::EX_T1_C];
		unpack_ext = r;
	endfunction

	// Enables that live in the shared mask; the rest are in the extended one
	localparam logic [9:0] SHARED_EN_SET = 10'h00f;
	localparam logic [9:0] EXT_EN_SET    = 10'h3f0;
	// Flags reset as a whole; the two padding bits are timer 3 overflow and compare C and reset to zero
	localparam logic [9:0] RST_FLAGS_ALL = {2'b00, tmi_pkg::RST_FLAGS};

	// Flag, enable and request state
	logic [9:0]  flag_reg;
	logic [9:0]  en_reg;
	logic [9:0]  irq_req_reg;
	logic [7:0]  io_rdata_reg;

	// Next values and combined terms
	logic [9:0]  flag_next;
	logic [9:0]  en_next;
	logic [9:0]  irq_req_next;
	logic [7:0]  io_rdata_next;
	logic [9:0]  en_eff;
	logic [9:0]  set_evt;
	logic [9:0]  sw_clear;
	logic [9:0]  clr_any;

	// Write strobes
	logic        wr_shared_flags;
	logic        wr_ext_flags;
	logic        wr_shared_en;
	logic        wr_ext_en;

	// Per-timer views so both timers share one generate body
	logic [15:0] cnt     [tmi_pkg::NUM_TMR];
	logic [15:0] cmp_a   [tmi_pkg::NUM_TMR];
	logic [15:0] cmp_b   [tmi_pkg::NUM_TMR];
	logic [15:0] cmp_c   [tmi_pkg::NUM_TMR];
	logic [15:0] cap_val [tmi_pkg::NUM_TMR];
	logic [3:0]  wmode   [tmi_pkg::NUM_TMR];
	logic        tick    [tmi_pkg::NUM_TMR];
	logic        mode_ovf[tmi_pkg::NUM_TMR];
	logic        rising  [tmi_pkg::NUM_TMR];
	logic        pin_raw [tmi_pkg::NUM_TMR];

	assign cnt[0]      = t1_counter;
	assign cnt[1]      = t3_counter;
	assign cmp_a[0]    = t1_compare_a;
	assign cmp_a[1]    = t3_compare_a;
	assign cmp_b[0]    = t1_compare_b;
	assign cmp_b[1]    = t3_compare_b;
	assign cmp_c[0]    = t1_compare_c;
	assign cmp_c[1]    = t3_compare_c;
	assign cap_val[0]  = t1_capture_value;
	assign cap_val[1]  = t3_capture_value;
	assign wmode[0]    = t1_waveform_mode_select;
	assign wmode[1]    = t3_waveform_mode_select;
	assign tick[0]     = t1_tick;
	assign tick[1]     = t3_tick;
	assign mode_ovf[0] = t1_mode_ovf_evt;
	assign mode_ovf[1] = t3_mode_ovf_evt;
	assign rising[0]   = t1_cap_rising;
	assign rising[1]   = t3_cap_rising;
	assign pin_raw[0]  = t1_capture_pin;
	assign pin_raw[1]  = t3_capture_pin;

	// Pin edges are ignored until the synchroniser has refilled after reset, so a
	// pin that idles high cannot fake an edge; pin events in those cycles are lost
	logic [1:0]  pin_settle_reg;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_settle_reg <= 2'h0;
		end else if (pin_settle_reg != 2'h3) begin
			pin_settle_reg <= pin_settle_reg + 2'h1;
		end
	end

	// Per-timer set events; index = timer * sources per timer + kind
	genvar t;
	generate
		for (t = 0; t < tmi_pkg::NUM_TMR; t++) begin : g_tmr
			logic pin_meta_reg;
			logic pin_sync_reg;
			logic pin_prev_reg;
			logic pin_rise;
			logic pin_fall;
			logic pin_edge;
			logic at_top;
			logic at_max;

			// Capture pins are asynchronous; edges come from the second and third flops, never the first
			always_ff @(posedge clock or negedge rstn) begin
				if (!rstn) begin
					pin_meta_reg <= 1'b0;
					pin_sync_reg <= 1'b0;
					pin_prev_reg <= 1'b0;
				end else begin
					pin_meta_reg <= pin_raw[t];
					pin_sync_reg <= pin_meta_reg;
					pin_prev_reg <= pin_sync_reg;
				end
			end

			assign pin_rise = pin_sync_reg & ~pin_prev_reg;
			assign pin_fall = ~pin_sync_reg & pin_prev_reg;
			// Edge select is a level on this clock and needs no synchroniser
			assign pin_edge = (pin_settle_reg == 2'h3) && (rising[t] ? pin_rise : pin_fall);
			assign at_top   = tick[t] && (cnt[t] == cap_val[t]);
			assign at_max   = tick[t] && (cnt[t] == tmi_pkg::CNT_MAX);

			// With capture as TOP the pin no longer reaches the flag
			assign set_evt[t*tmi_pkg::SRC_PER_TMR + tmi_pkg::K_CAP] =
				cap_is_top(wmode[t]) ? at_top : pin_edge;

			// Only a counted equality sets these; force strobes never enter here
			assign set_evt[t*tmi_pkg::SRC_PER_TMR + tmi_pkg::K_A] =
				tick[t] && (cnt[t] == cmp_a[t]);
			assign set_evt[t*tmi_pkg::SRC_PER_TMR + tmi_pkg::K_B] =
				tick[t] && (cnt[t] == cmp_b[t]);
			assign set_evt[t*tmi_pkg::SRC_PER_TMR + tmi_pkg::K_C] =
				tick[t] && (cnt[t] == cmp_c[t]);

			// PWM modes hand over their own overflow point
			assign set_evt[t*tmi_pkg::SRC_PER_TMR + tmi_pkg::K_OVF] =
				ovf_at_max(wmode[t]) ? at_max : mode_ovf[t];
		end
	endgenerate

	// Register decode
	// Writes to the extended mask are dropped while it is hidden
	assign wr_shared_flags = io_wr && reg_hit(io_addr, tmi_pkg::OFF_SHARED_FLAGS);
	assign wr_shared_en    = io_wr && reg_hit(io_addr, tmi_pkg::OFF_SHARED_EN);
	assign wr_ext_flags    = io_wr && reg_hit(io_addr, tmi_pkg::OFF_EXT_FLAGS);
	assign wr_ext_en       = io_wr && reg_hit(io_addr, tmi_pkg::OFF_EXT_EN) && !legacy_mode;

	// Only ones clear; a zero written to a flag bit leaves it alone
	assign sw_clear = (wr_shared_flags ? unpack_shared(io_wdata) : 10'h000)
		| (wr_ext_flags ? unpack_ext(io_wdata) : 10'h000);
	assign clr_any  = sw_clear | vec_taken;

	// A set in the same cycle as a clear wins, so no event is lost
	genvar s;
	generate
		for (s = 0; s < tmi_pkg::NUM_SRC; s++) begin : g_flag
			assign flag_next[s] = set_evt[s] | (flag_reg[s] & ~clr_any[s]);
		end
	endgenerate

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flag_reg <= RST_FLAGS_ALL;
		end else begin
			flag_reg <= flag_next;
		end
	end

	// Enables: each window writes only its own bits, so one mask write never
	// disturbs the other mask even though both live in one vector
	always_comb begin
		en_next = en_reg;
		if (wr_shared_en) begin
			en_next = (en_reg & EXT_EN_SET) | (unpack_shared(io_wdata) & SHARED_EN_SET);
		end
		if (wr_ext_en) begin
			en_next = (en_reg & SHARED_EN_SET) | (unpack_ext(io_wdata) & EXT_EN_SET);
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			en_reg <= {2'b00, tmi_pkg::RST_EN};
		end else begin
			en_reg <= en_next;
		end
	end

	// Legacy mode removes the extended mask from gating as well as from view;
	// flags keep setting, so leaving legacy mode can raise a request at once
	assign en_eff = legacy_mode ? (en_reg & SHARED_EN_SET) : en_reg;

	assign irq_req_next = flag_reg & en_eff
		& {tmi_pkg::NUM_SRC{global_irq_en}};

	// One cycle of latency is traded for a flop-driven request line
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			irq_req_reg <= 10'h000;
		end else begin
			irq_req_reg <= irq_req_next;
		end
	end

	// Read data only moves on a read, so the last value stands between reads
	always_comb begin
		io_rdata_next = io_rdata_reg;
		if (io_rd) begin
			if (reg_hit(io_addr, tmi_pkg::OFF_SHARED_FLAGS)) begin
				io_rdata_next = pack_shared(flag_reg);
			end else if (reg_hit(io_addr, tmi_pkg::OFF_SHARED_EN)) begin
				io_rdata_next = pack_shared(en_reg);
			end else if (reg_hit(io_addr, tmi_pkg::OFF_EXT_FLAGS)) begin
				io_rdata_next = pack_ext(flag_reg);
			end else if (reg_hit(io_addr, tmi_pkg::OFF_EXT_EN) && !legacy_mode) begin
				io_rdata_next = pack_ext(en_reg);
			end else begin
				// Unmapped, or the extended mask while it is hidden
				io_rdata_next = 8'h00;
			end
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			io_rdata_reg <= tmi_pkg::RST_RDATA;
		end else begin
			io_rdata_reg <= io_rdata_next;
		end
	end

	assign io_rdata = io_rdata_reg;
	assign irq_req  = irq_req_reg;

endmodule

// >>> src/tmi_pkg.sv
package tmi_pkg;

	// Register port
	localparam int          ADDR_W = 8;
	localparam int          DATA_W = 8;

	// Register offsets on the I/O register port
	localparam logic [7:0]  OFF_SHARED_FLAGS = 8'h36;
	localparam logic [7:0]  OFF_SHARED_EN    = 8'h37;
	localparam logic [7:0]  OFF_EXT_FLAGS    = 8'h7c;
	localparam logic [7:0]  OFF_EXT_EN       = 8'h7d;

	// Reset values
	localparam logic [7:0]  RST_FLAGS = 8'h00;
	localparam logic [7:0]  RST_EN    = 8'h00;
	localparam logic [7:0]  RST_RDATA = 8'h00;

	// Shared register field positions (timer 1)
	localparam int          SH_T1_CAP = 5;
	localparam int          SH_T1_A   = 4;
	localparam int          SH_T1_B   = 3;
	localparam int          SH_T1_OVF = 2;

	// Extended register field positions
	localparam int          EX_T3_CAP = 5;
	localparam int          EX_T3_A   = 4;
	localparam int          EX_T3_B   = 3;
	localparam int          EX_T3_OVF = 2;
	localparam int          EX_T3_C   = 1;
	localparam int          EX_T1_C   = 0;

	// Sources: index = timer * SRC_PER_TMR + kind
	localparam int          NUM_TMR     = 2;
	localparam int          SRC_PER_TMR = 5;
	localparam int          NUM_SRC     = 10;
	localparam int          K_CAP       = 0;
	localparam int          K_A         = 1;
	localparam int          K_B         = 2;
	localparam int          K_OVF       = 3;
	localparam int          K_C         = 4;

	// Waveform modes that matter to the flags
	localparam logic [3:0]  WGM_NORMAL  = 4'h0;
	localparam logic [3:0]  WGM_CTC_OCR = 4'h4;
	localparam logic [3:0]  WGM_CTC_ICR = 4'hc;
	localparam logic [3:0]  WGM_PFC_ICR = 4'h8;
	localparam logic [3:0]  WGM_PC_ICR  = 4'ha;
	localparam logic [3:0]  WGM_FAST_ICR = 4'he;

	// Counter extreme
	localparam logic [15:0] CNT_MAX = 16'hffff;

endpackage

// >>> tb/tmi_cpu_model.sv
`timescale 1ns/1ps
module tmi_cpu_model (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       rstn,
	// Vector side
	input  wire logic       ack_en,
	input  wire logic [9:0] irq_req,
	output logic      [9:0] vec_taken
);
	logic [9:0] pick;
	logic [1:0] gap_reg;
	// Lowest index wins, like a fixed-priority vector table
	assign pick = irq_req & (~irq_req + 10'h1);
	// Holdoff spans the cycles the level needs to fall
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			vec_taken <= 10'h0;
			gap_reg <= 2'h0;
		end else if (gap_reg != 2'h0) begin
			vec_taken <= 10'h0;
			gap_reg <= gap_reg - 2'h1;
		end else if (ack_en && irq_req != 10'h0) begin
			vec_taken <= pick;
			gap_reg <= 2'h3;
		end
	end
endmodule

// >>> tb/tmi_flags_asserts.sv
`timescale 1ns/1ps
module tmi_flags_asserts (
	// Clock and reset
	input wire logic        clock,
	input wire logic        rstn,
	// Watched ports
	input wire logic        legacy_mode,
	input wire logic        global_irq_en,
	input wire logic [7:0]  io_addr,
	input wire logic        io_wr,
	input wire logic        io_rd,
	input wire logic [7:0]  io_wdata,
	input wire logic [7:0]  io_rdata,
	input wire logic        t1_tick,
	input wire logic [15:0] t1_counter,
	input wire logic [15:0] t1_compare_b,
	input wire logic [9:0]  vec_taken,
	input wire logic [9:0]  irq_req
);
	logic b_hit;
	logic mapped;
	logic sh_rd;
	assign b_hit = t1_tick && t1_counter == t1_compare_b;
	assign mapped = io_addr inside {8'h36, 8'h37, 8'h7c, 8'h7d};
	assign sh_rd = io_rd && io_addr == tmi_pkg::OFF_SHARED_FLAGS;
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	no_global_a: assert property (!$past(global_irq_en) |-> irq_req == 10'h0)
		else $error("request while interrupts off");
	legacy_req_a: assert property ($past(legacy_mode) |-> irq_req[9:4] == 6'h0)
		else $error("extended request in legacy mode");
	unmapped_rd_a: assert property (io_rd && !mapped |=> io_rdata == 8'h0)
		else $error("unmapped read not zero");
	legacy_rd_a: assert property (io_rd && legacy_mode && io_addr == 8'h7d |=> io_rdata == 8'h0)
		else $error("extended mask visible in legacy mode");
	shared_bits_a: assert property (io_rd && io_addr[7:1] == 7'h1b |=> (io_rdata & 8'hc3) == 8'h0)
		else $error("foreign shared bits set");
	rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data moved without read");
	cmp_set_a: assert property (b_hit ##1 sh_rd |=> io_rdata[3])
		else $error("compare flag not set");
	wr_clear_a: assert property (io_wr && io_addr == 8'h36 && io_wdata[3] && !b_hit ##1 sh_rd |=> !io_rdata[3])
		else $error("compare flag not cleared");
	c_irq: cover property ($rose(irq_req[2]));
	c_vec: cover property (vec_taken != 10'h0);
	c_leg: cover property (io_rd && legacy_mode);
endmodule
bind tmi_flags tmi_flags_asserts chk (.clock(clock), .rstn(rstn), .legacy_mode(legacy_mode),
	.global_irq_en(global_irq_en), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
	.io_rdata(io_rdata), .t1_tick(t1_tick), .t1_counter(t1_counter), .t1_compare_b(t1_compare_b),
	.vec_taken(vec_taken), .irq_req(irq_req));

// >>> tb/test_tmi_flags.sv
`timescale 1ns/1ps
module test_tmi_flags;
	logic        clock = 1'b0;
	logic        rstn = 1'b0;
	logic        legacy_mode = 1'b0;
	logic        global_irq_en = 1'b0;
	logic        io_wr = 1'b0;
	logic        io_rd = 1'b0;
	logic        ack_en = 1'b0;
	logic [7:0]  io_addr = 8'h0;
	logic [7:0]  io_wdata = 8'h0;
	logic [7:0]  io_rdata;
	logic [15:0] cnt[2] = '{2{16'h0}};
	logic [15:0] ca[2] = '{2{16'h1}};
	logic [15:0] cb[2] = '{2{16'h1}};
	logic [15:0] cc[2] = '{2{16'h1}};
	logic [15:0] cv[2] = '{2{16'h1}};
	logic [3:0]  wm[2] = '{2{4'h0}};
	logic        tk[2] = '{2{1'b0}};
	logic        oe[2] = '{2{1'b0}};
	logic        cr[2] = '{2{1'b1}};
	logic        cp[2] = '{2{1'b0}};
	logic [9:0]  vec_taken;
	logic [9:0]  irq_req;
	int          n_mismatch = 0;
	int          n_compared = 0;
	logic [7:0]  msk_list[5] = '{8'h36, 8'h37, 8'h7c, 8'h7d, 8'h40};
	tmi_flags dut (.clock(clock), .rstn(rstn), .legacy_mode(legacy_mode), .global_irq_en(global_irq_en),
		.io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
		.t1_tick(tk[0]), .t1_counter(cnt[0]), .t1_compare_a(ca[0]), .t1_compare_b(cb[0]),
		.t1_compare_c(cc[0]), .t1_capture_value(cv[0]), .t1_waveform_mode_select(wm[0]),
		.t1_mode_ovf_evt(oe[0]), .t1_cap_rising(cr[0]), .t1_capture_pin(cp[0]),
		.t3_tick(tk[1]), .t3_counter(cnt[1]), .t3_compare_a(ca[1]), .t3_compare_b(cb[1]),
		.t3_compare_c(cc[1]), .t3_capture_value(cv[1]), .t3_waveform_mode_select(wm[1]),
		.t3_mode_ovf_evt(oe[1]), .t3_cap_rising(cr[1]), .t3_capture_pin(cp[1]),
		.vec_taken(vec_taken), .irq_req(irq_req));
	tmi_cpu_model cpu (.clock(clock), .rstn(rstn), .ack_en(ack_en), .irq_req(irq_req), .vec_taken(vec_taken));
	initial begin
		forever #4 clock = ~clock;
	end
	task automatic step;
		@(posedge clock);
		#1;
	endtask
	task automatic fail(input string m);
		n_mismatch++;
		$display("mismatch %0t %s", $time, m);
	endtask
	task automatic finish_test;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		io_wr = 1'b1;
		io_addr = a;
		io_wdata = d;
		step;
		io_wr = 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		io_rd = 1'b1;
		io_addr = a;
		step;
		io_rd = 1'b0;
		n_compared++;
		if (io_rdata !== e) fail("register read");
	endtask
	task automatic irq_chk(input logic [9:0] e);
		n_compared++;
		if (irq_req !== e) fail("request level");
	endtask
	function automatic logic [7:0] adr(input int k);
		return (k < 4) ? tmi_pkg::OFF_SHARED_FLAGS : tmi_pkg::OFF_EXT_FLAGS;
	endfunction
	function automatic logic [7:0] msk(input int k);
		if (k == 4) return 8'h01;
		if (k == 9) return 8'h02;
		return 8'h20 >> (k % 5);
	endfunction
	// Only the chosen value matches; every other compare sits at its inverse
	task automatic fire(input int k, input logic on);
		int t;
		logic [15:0] v;
		t = k / 5;
		v = (k % 5 == 3) ? 16'hffff : 16'($urandom_range(32767));
		cnt[t] = v;
		{ca[t], cb[t], cc[t], cv[t]} = {4{~v}};
		case (k % 5)
			0: cv[t] = v;
			1: ca[t] = v;
			2: cb[t] = v;
			4: cc[t] = v;
			default: ;
		endcase
		wm[t] = (k % 5 == 0) ? tmi_pkg::WGM_CTC_ICR : tmi_pkg::WGM_NORMAL;
		tk[t] = on;
		step;
		tk[t] = 1'b0;
	endtask
	initial begin
		void'($urandom(14033));
		repeat (3) @(posedge clock);
		#1;
		rstn = 1'b1;
		foreach (msk_list[i]) rd_chk(msk_list[i], 8'h00);
		wr(8'h37, 8'hff);
		rd_chk(8'h37, 8'h3c);
		legacy_mode = 1'b1;
		wr(8'h7d, 8'hff);
		rd_chk(8'h7d, 8'h00);
		legacy_mode = 1'b0;
		rd_chk(8'h7d, 8'h00);
		wr(8'h7d, 8'hff);
		rd_chk(8'h7d, 8'h3f);
		for (int k = 0; k < 10; k++) begin
			fire(k, 1'b0);
			rd_chk(adr(k), 8'h00);
			fire(k, 1'b1);
			rd_chk(adr(k), msk(k));
			irq_chk(10'h0);
			global_irq_en = 1'b1;
			step;
			step;
			irq_chk(10'h1 << k);
			wr(adr(k), msk(k));
			rd_chk(adr(k), 8'h00);
			irq_chk(10'h0);
			ack_en = 1'b1;
			fire(k, 1'b1);
			for (int i = 0; i <= 16 && vec_taken === 10'h0; i++) begin
				if (i == 16) begin
					fail("no vector");
					finish_test;
				end
				step;
			end
			step;
			rd_chk(adr(k), 8'h00);
			ack_en = 1'b0;
			global_irq_en = 1'b0;
		end
		for (int t = 0; t < 2; t++) begin
			wm[t] = 4'h1;
			cnt[t] = 16'hffff;
			{ca[t], cb[t], cc[t], cv[t]} = {4{16'h0001}};
			tk[t] = 1'b1;
			step;
			rd_chk(adr(5 * t + 3), 8'h00);
			oe[t] = 1'b1;
			step;
			oe[t] = 1'b0;
			tk[t] = 1'b0;
			rd_chk(adr(5 * t + 3), msk(5 * t + 3));
			wr(adr(5 * t), 8'hff);
			wm[t] = 4'h0;
			cp[t] = 1'b1;
			repeat (5) step;
			rd_chk(adr(5 * t), msk(5 * t));
			wr(adr(5 * t), msk(5 * t));
			cr[t] = 1'b0;
			cp[t] = 1'b0;
			repeat (5) step;
			rd_chk(adr(5 * t), msk(5 * t));
			wr(adr(5 * t), msk(5 * t));
			cr[t] = 1'b1;
			repeat (5) step;
			rd_chk(adr(5 * t), 8'h00);
		end
		finish_test;
	end
endmodule
